/* src/brf_params.svh */
// constants for the banked register file and stack logic
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH
// ----------------------------------------
// register area and windows (low placement)
// ----------------------------------------
`define BRF_REG_AREA_LO   24'h00FE80
`define BRF_REG_AREA_HI   24'h00FEFF
`define BRF_BANK0_BASE    24'h00FEF0
`define BRF_SFR_BASE      24'h00FF00
`define BRF_HIGH_OFFSET   24'h0F0000
// ----------------------------------------
// axi register offsets
// ----------------------------------------
`define BRF_OFS_CTRL      8'h00
`define BRF_OFS_STACK     8'h04
`define BRF_OFS_PC        8'h08
`define BRF_OFS_STATUS    8'h0C
`define BRF_OFS_CMD       8'h10
`define BRF_OFS_RDATA     8'h14
`define BRF_OFS_EXT       8'h18
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BRF_PSW_SWAP_BIT  5
`define BRF_PSW_BANK_LSB  12
`define BRF_PSW_RESET     16'h0000
`define BRF_PSW_SAVE_MASK 16'hF0FF
`endif

/* src/brf_pkg.sv */
// types for the banked register file and stack logic
package brf_pkg;
  // command codes issued through the command register
  typedef enum logic [3:0] {
    BRF_CMD_NONE   = 4'h0,
    BRF_CMD_RD8    = 4'h1,
    BRF_CMD_WR8    = 4'h2,
    BRF_CMD_RD16   = 4'h3,
    BRF_CMD_WR16   = 4'h4,
    BRF_CMD_RD24   = 4'h5,
    BRF_CMD_BANK   = 4'h6,
    BRF_CMD_CTXSW  = 4'h7,
    BRF_CMD_POP1   = 4'h8,
    BRF_CMD_POP2   = 4'h9,
    BRF_CMD_POP3   = 4'hA,
    BRF_CMD_POPPSW = 4'hB,
    BRF_CMD_PUSH   = 4'hC,
    BRF_CMD_FUNC   = 4'hD
  } brf_cmd_e;
  // one-hot sequencer states
  typedef enum logic [3:0] {
    BRF_ST_IDLE = 4'b0001,
    BRF_ST_EXEC = 4'b0010,
    BRF_ST_CTX2 = 4'b0100,
    BRF_ST_LOCK = 4'b1000
  } brf_state_e;
  // axi-lite write request
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
  } brf_axi_wreq_s;
  // axi-lite read request
  typedef struct packed {
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } brf_axi_rreq_s;
  // all state of the block except the ram and extension bytes
  typedef struct packed {
    brf_state_e  st;
    logic [15:0] program_status_word;
    logic [23:0] sp;
    logic [19:0] pc;
    logic        high_place;
    logic [31:0] cmd;
    logic [31:0] rdata;
    logic [31:0] ext;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rd_bus;
    logic [1:0]  rresp;
    logic        busy;
  } brf_state_s;
endpackage

/* src/brf_regfile.sv */
// banked register file, address map and stack pointer logic
// ----------------------------------------
// ----------------------------------------
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "brf_params.svh"

module brf_regfile
  import brf_pkg::*;
(
  input  wire logic          clk_sys_in,    // 40 MHz system clock
  input  wire logic          rst_in,        // synchronous reset, high
  input  wire brf_axi_wreq_s axi_wreq_in,   // write address, data, bready
  input  wire brf_axi_rreq_s axi_rreq_in,   // read address, rready
  output logic               awready_out,   // write address taken
  output logic               wready_out,    // write data taken
  output logic               bvalid_out,    // write response valid
  output logic [1:0]         bresp_out,     // write response code
  output logic               arready_out,   // read address taken
  output logic               rvalid_out,    // read data valid
  output logic [31:0]        rdata_out,     // read data
  output logic [1:0]         rresp_out,     // read response code
  output logic               lockup_out     // special window deadlock
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0]  ram_q [0:127];     // 8 banks x 16 bytes of internal ram
  logic [7:0]  ext_q [0:31];      // extension bytes, bank x 4, outside ram
  brf_state_s  s_r;               // registered state
  brf_state_s  s_nxt;             // next state
  logic        ram_we;            // ram byte write strobe
  logic [6:0]  ram_wa;            // ram write address
  logic [7:0]  ram_wd;            // ram write data
  logic        ram_we2;           // second byte of a pair write
  logic [7:0]  ram_wd2;           // high byte data
  logic        ext_we;            // extension write strobe
  logic [4:0]  ext_wa;            // extension write address
  logic [7:0]  ext_wd;            // extension write data

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // ram index of byte n in bank b; bank 0 at top of area
  function automatic logic [6:0] ram_idx(input logic [2:0] b, input logic [3:0] n);
    ram_idx = {~b, n};
  endfunction

  // absolute byte index for a function name code under the swap bit
  // codes: 0 x, 1 a, 2 c, 3 b; others pass through unchanged
  function automatic logic [3:0] func_map(input logic [3:0] code, input logic swap);
    if (code < 4'h4 && swap) begin
      func_map = code + 4'h4;
    end else begin
      func_map = code;
    end
  endfunction

  // stack pop size from command
  function automatic logic [23:0] pop_step(input brf_cmd_e c);
    unique case (c)
      BRF_CMD_POP1:   pop_step = 24'h000001;
      BRF_CMD_POP3:   pop_step = 24'h000003;
      default:        pop_step = 24'h000002;
    endcase
  endfunction

  // ----------------------------------------
  // address decode of a cpu data address
  // ----------------------------------------
  logic [23:0] plc_ofs;       // placement offset
  logic [23:0] cmd_addr;      // address given in ext register
  logic        hit_regarea;   // address in register alias
  logic        hit_sfr;       // address in special window
  logic [6:0]  alias_idx;     // ram index of alias
  always_comb begin
    plc_ofs     = s_r.high_place ? `BRF_HIGH_OFFSET : 24'h000000;
    cmd_addr    = s_r.ext[23:0];
    hit_regarea = (cmd_addr >= (`BRF_REG_AREA_LO + plc_ofs)) &&
                  (cmd_addr <= (`BRF_REG_AREA_HI + plc_ofs));
    hit_sfr     = (cmd_addr[23:8] == 16'((`BRF_SFR_BASE + plc_ofs) >> 8));
    alias_idx   = cmd_addr[6:0];
  end

  // ----------------------------------------
  // command field extraction
  // ----------------------------------------
  brf_cmd_e    cmd_op;     // opcode
  logic [3:0]  cmd_reg;    // register number or function code
  logic        cmd_fn;     // treat number as function name
  logic [15:0] cmd_wd;     // write data
  logic [2:0]  bank;       // active bank
  logic [3:0]  reg_n;      // resolved byte index
  logic [3:0]  pair_lo;    // even byte index of pair
  logic [6:0]  ra_lo;      // ram index low byte
  logic [6:0]  ra_hi;      // ram index high byte
  always_comb begin
    cmd_op  = brf_cmd_e'(s_r.cmd[3:0]);
    cmd_reg = s_r.cmd[7:4];
    cmd_fn  = s_r.cmd[8];
    cmd_wd  = s_r.cmd[31:16];
    bank    = s_r.program_status_word[`BRF_PSW_BANK_LSB +: 3];
    reg_n   = cmd_fn ? func_map(cmd_reg, s_r.program_status_word[`BRF_PSW_SWAP_BIT]) : cmd_reg;
    pair_lo = {reg_n[2:0], 1'b0}; // pair k at offset 2k
    ra_lo   = ram_idx(bank, pair_lo);
    ra_hi   = ram_idx(bank, pair_lo + 4'h1);
  end

  // ----------------------------------------
  // axi-lite handshake outputs
  // ----------------------------------------
  always_comb begin
    awready_out = !s_r.aw_got && !s_r.bvalid;
    wready_out  = !s_r.w_got && !s_r.bvalid;
    arready_out = !s_r.rvalid;
    bvalid_out  = s_r.bvalid;
    bresp_out   = s_r.bresp;
    rvalid_out  = s_r.rvalid;
    rdata_out   = s_r.rd_bus;
    rresp_out   = s_r.rresp;
    lockup_out  = (s_r.st == BRF_ST_LOCK);
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic [7:0]  aw_a;   // effective write address
  logic [31:0] w_d;    // effective write data
  logic        do_wr;  // both halves present
  always_comb begin
    s_nxt   = s_r;
    ram_we  = 1'b0;
    ram_we2 = 1'b0;
    ram_wa  = ra_lo;
    ram_wd  = cmd_wd[7:0];
    ram_wd2 = cmd_wd[15:8];
    ext_we  = 1'b0;
    ext_wa  = {bank, reg_n[1:0]};
    ext_wd  = cmd_wd[7:0];
    // capture write channels in either order
    if (axi_wreq_in.awvalid && awready_out) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = axi_wreq_in.awaddr;
    end
    if (axi_wreq_in.wvalid && wready_out) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = axi_wreq_in.wdata;
    end
    aw_a  = s_r.aw_got ? s_r.aw_addr : axi_wreq_in.awaddr;
    w_d   = s_r.w_got ? s_r.w_data : axi_wreq_in.wdata;
    do_wr = s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid;
    // write completion
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = 2'b00;
      unique case (aw_a)
        `BRF_OFS_CTRL:  s_nxt.high_place = w_d[0];
        `BRF_OFS_STACK: s_nxt.sp = w_d[23:0];
        `BRF_OFS_PC:    s_nxt.pc = w_d[19:0];
        `BRF_OFS_STATUS: s_nxt.program_status_word = w_d[15:0];
        `BRF_OFS_EXT:   s_nxt.ext = w_d;
        `BRF_OFS_CMD: begin
          if (s_r.st == BRF_ST_IDLE) begin
            s_nxt.cmd  = w_d;
            s_nxt.busy = 1'b1;
            s_nxt.st   = BRF_ST_EXEC;
          end else begin
            s_nxt.bresp = 2'b10; // busy or locked
          end
        end
        default: s_nxt.bresp = 2'b10; // unmapped offset
      endcase
    end
    if (s_r.bvalid && axi_wreq_in.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // read channel
    if (axi_rreq_in.arvalid && arready_out) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = 2'b00;
      unique case (axi_rreq_in.araddr)
        `BRF_OFS_CTRL:   s_nxt.rd_bus = {31'h00000000, s_r.high_place};
        `BRF_OFS_STACK:  s_nxt.rd_bus = {8'h00, s_r.sp};
        `BRF_OFS_PC:     s_nxt.rd_bus = {12'h000, s_r.pc};
        `BRF_OFS_STATUS: s_nxt.rd_bus = {16'h0000, s_r.program_status_word}; // bank flags visible
        `BRF_OFS_CMD:    s_nxt.rd_bus = {26'h0000000, lockup_out, s_r.busy, s_r.cmd[3:0]};
        `BRF_OFS_RDATA:  s_nxt.rd_bus = s_r.rdata;
        `BRF_OFS_EXT:    s_nxt.rd_bus = s_r.ext;
        default: begin
          s_nxt.rd_bus = 32'h00000000;
          s_nxt.rresp  = 2'b10;
        end
      endcase
    end else if (s_r.rvalid && axi_rreq_in.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // command sequencer
    unique case (s_r.st)
      BRF_ST_IDLE: ;
      BRF_ST_LOCK: ; // held until reset
      BRF_ST_EXEC: begin
        s_nxt.st   = BRF_ST_IDLE;
        s_nxt.busy = 1'b0;
        unique case (cmd_op)
          BRF_CMD_RD8, BRF_CMD_FUNC: begin
            s_nxt.rdata = {24'h000000, ram_q[ram_idx(bank, reg_n)]};
          end
          BRF_CMD_WR8: begin
            ram_we = 1'b1;
            ram_wa = ram_idx(bank, reg_n);
          end
          BRF_CMD_RD16: begin
            // low address is low byte quad = primary with pair 6
            s_nxt.rdata = {ram_q[ram_idx(bank, 4'hD)], ram_q[ram_idx(bank, 4'hC)],
                           ram_q[ra_hi], ram_q[ra_lo]};
          end
          BRF_CMD_WR16: begin
            ram_we  = 1'b1;
            ram_we2 = 1'b1;
          end
          BRF_CMD_RD24: begin
            // pointers 4..7: pair k plus its extension byte
            s_nxt.rdata = {8'h00, ext_q[{bank, reg_n[1:0]}], ram_q[ra_hi], ram_q[ra_lo]};
          end
          BRF_CMD_BANK: begin
            s_nxt.program_status_word[`BRF_PSW_BANK_LSB +: 3] = cmd_reg[2:0];
            if (cmd_fn) begin
              ext_we = 1'b1; // extension write when flagged
            end
          end
          BRF_CMD_CTXSW: begin
            s_nxt.program_status_word[`BRF_PSW_BANK_LSB +: 3] = cmd_reg[2:0];
            s_nxt.st   = BRF_ST_CTX2;
            s_nxt.busy = 1'b1;
          end
          BRF_CMD_POP1, BRF_CMD_POP2, BRF_CMD_POP3: begin
            s_nxt.sp = s_r.sp + pop_step(cmd_op); // post-increment
          end
          BRF_CMD_POPPSW: begin
            // unsaved nibble of the high byte kept
            s_nxt.program_status_word = (cmd_wd & `BRF_PSW_SAVE_MASK) | (s_r.program_status_word & ~`BRF_PSW_SAVE_MASK);
            s_nxt.sp  = s_r.sp + 24'h000002;
          end
          BRF_CMD_PUSH: begin
            s_nxt.sp = s_r.sp - {22'h000000, s_r.cmd[5:4]}; // pre-decrement
          end
          default: ;
        endcase
        // any special window access locks; a register area access reads the alias byte
        if (s_r.cmd[9] && hit_sfr) begin
          s_nxt.st = BRF_ST_LOCK;
        end else if (s_r.cmd[9] && hit_regarea) begin
          s_nxt.rdata = {24'h000000, ram_q[alias_idx]};
        end
      end
      BRF_ST_CTX2: begin
        // save pc low into pair two of the new bank
        s_nxt.st   = BRF_ST_IDLE;
        s_nxt.busy = 1'b0;
        ram_we  = 1'b1;
        ram_we2 = 1'b1;
        ram_wa  = ram_idx(bank, 4'h4);
        ram_wd  = s_r.pc[7:0];
        ram_wd2 = s_r.pc[15:8];
      end
      default: s_nxt.st = BRF_ST_IDLE;
    endcase
  end

  // pair three data for the context save; taken in the execute cycle, while the
  // status still holds the interrupted bank, and written into the new bank
  logic [15:0] ctx_hi;   // pc high nibble with masked status
  logic        ctx_we;   // pair three save strobe
  logic [2:0]  ctx_bank; // bank being switched to
  always_comb begin
    ctx_hi   = (s_r.program_status_word & `BRF_PSW_SAVE_MASK) | {4'h0, s_r.pc[19:16], 8'h00};
    ctx_we   = (s_r.st == BRF_ST_EXEC) && (cmd_op == BRF_CMD_CTXSW);
    ctx_bank = cmd_reg[2:0];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_r        <= '0;
      s_r.st     <= BRF_ST_IDLE;
      s_r.program_status_word    <= `BRF_PSW_RESET; // bank 0
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // ram and extension writes
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
    if (ram_we2) begin
      ram_q[ram_wa + 7'h01] <= ram_wd2; // high byte above low
    end
    if (ctx_we) begin
      ram_q[ram_idx(ctx_bank, 4'h6)] <= ctx_hi[7:0];
      ram_q[ram_idx(ctx_bank, 4'h7)] <= ctx_hi[15:8];
    end
    if (ext_we) begin
      ext_q[ext_wa] <= ext_wd;
    end
  end

endmodule

/* dv/brf_regfile_assertions.sv */
// port-level checks for the banked register file block
`include "brf_params.svh"

module brf_regfile_assertions
  import brf_pkg::*;
(
  input wire logic          clk_sys_in,   // system clock
  input wire logic          rst_in,       // synchronous reset, high
  input wire brf_axi_wreq_s axi_wreq_in,  // write request
  input wire brf_axi_rreq_s axi_rreq_in,  // read request
  input wire logic          awready_out,  // write address taken
  input wire logic          wready_out,   // write data taken
  input wire logic          bvalid_out,   // write response valid
  input wire logic [1:0]    bresp_out,    // write response code
  input wire logic          arready_out,  // read address taken
  input wire logic          rvalid_out,   // read data valid
  input wire logic [31:0]   rdata_out,    // read data
  input wire logic [1:0]    rresp_out,    // read response code
  input wire logic          lockup_out    // deadlock flag
);
  // ----------------------------------------
  // clocking and handshake sequences
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // both write halves taken at one edge
  sequence s_wr_taken;
    axi_wreq_in.awvalid && awready_out && axi_wreq_in.wvalid && wready_out;
  endsequence
  // read address taken
  sequence s_rd_taken;
    axi_rreq_in.arvalid && arready_out;
  endsequence
  // command offset addressed while deadlocked
  sequence s_cmd_locked;
    lockup_out && axi_wreq_in.awaddr == `BRF_OFS_CMD;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_write_answer: assert property (s_wr_taken |=> bvalid_out)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> rvalid_out)
    else $error("read response late");
  a_bresp_hold: assert property (bvalid_out && !axi_wreq_in.bready |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid_out && !axi_rreq_in.rready |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped");
  a_b_done: assert property (bvalid_out && axi_wreq_in.bready |=> !bvalid_out)
    else $error("write response repeated");
  a_wr_blocked: assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write taken while response pending");
  a_err_zero: assert property (rvalid_out && rresp_out == 2'b10 |-> rdata_out == 32'h0)
    else $error("error read carries data");
  a_lock_holds: assert property ($rose(lockup_out) |=> lockup_out [*4])
    else $error("lockup released without reset");
  a_lock_refuse: assert property (s_wr_taken and s_cmd_locked |=> bresp_out == 2'b10)
    else $error("command accepted while locked");
  a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !lockup_out && !bvalid_out && !rvalid_out)
    else $error("outputs active after reset");
endmodule

bind brf_regfile brf_regfile_assertions brf_regfile_assertions_i (
  .clk_sys_in, .rst_in, .axi_wreq_in, .axi_rreq_in, .awready_out, .wready_out, .bvalid_out,
  .bresp_out, .arready_out, .rvalid_out, .rdata_out, .rresp_out, .lockup_out);

/* dv/brf_regfile_tb_top.sv */
// self-checking bench for the banked register file block
`include "brf_params.svh"

module brf_regfile_tb_top
  import brf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and tables
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] c;  // command word
    logic [31:0] m;  // compare mask
    logic [31:0] e;  // expected result
  } brf_row_s;
  logic          clk_sys_in = 1'b0;  // bench clock
  logic          rst_in     = 1'b1;  // reset, high
  brf_axi_wreq_s wq         = '0;    // write request
  brf_axi_rreq_s rq         = '0;    // read request
  logic          awready, wready, bvalid, arready, rvalid, lockup;
  logic [1:0]    bresp, rresp, r;
  logic [31:0]   rdata, d;
  int            errors     = 0;     // mismatches
  int            checked    = 0;     // comparisons
  brf_row_s      rows [10]  = '{
    '{32'h1234_0064, 32'h0, 32'h0},                  // pair six
    '{32'hBEEF_0004, 32'h0, 32'h0},                  // pair zero
    '{32'h0000_0003, 32'hFFFF_FFFF, 32'h1234_BEEF},  // quad read
    '{32'h0000_0001, 32'hFF, 32'hEF},                // byte zero
    '{32'h0000_0011, 32'hFF, 32'hBE},                // byte one
    '{32'h0077_00D2, 32'h0, 32'h0},                  // byte thirteen
    '{32'h0000_0063, 32'hFFFF, 32'h7734},            // pair six again
    '{32'h00AB_0166, 32'h0, 32'h0},                  // extension six into bank zero, select bank six
    '{32'h0000_0006, 32'h0, 32'h0},                  // back to bank zero
    '{32'h0000_0065, 32'hFFFF_FFFF, 32'h00AB_7734}   // pointer six
  };
  logic [31:0]   pops [5]   = '{32'h8, 32'h9, 32'hA, 32'h2C, 32'hB};
  logic [23:0]   sps [5]    = '{24'h001001, 24'h001003, 24'h001006, 24'h001004, 24'h001006};
  logic [24:0]   xa [4]     = '{25'h000FEF0, 25'h10FFE80, 25'h100FF10, 25'h10FFF10};
  logic [7:0]    xd [4]     = '{8'hA0, 8'hA7, 8'hA7, 8'hA7};  // alias byte expected for the first two; the last two expect the held read data

  brf_regfile brf_regfile_i (
    .clk_sys_in (clk_sys_in), .rst_in (rst_in), .axi_wreq_in (wq), .axi_rreq_in (rq),
    .awready_out (awready), .wready_out (wready), .bvalid_out (bvalid), .bresp_out (bresp),
    .arready_out (arready), .rvalid_out (rvalid), .rdata_out (rdata), .rresp_out (rresp),
    .lockup_out (lockup));

  // 25 ns period
  always #12.5 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic hang();
    errors++;
    $display("CHECK FAILED %0t handshake timeout", $time);
    end_sim();
  endtask
  // axi write, halves released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wq <= '{1'b1, a, 1'b1, v, 4'hF, 1'b1};
    do begin
      @(posedge clk_sys_in);
      n++;
      if (wq.awvalid && awready) wq.awvalid <= 1'b0;
      if (wq.wvalid && wready) wq.wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) hang();
    rs = bresp;
    wq.bready <= 1'b0;
  endtask
  // axi read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    rq <= '{1'b1, a, 1'b1};
    do begin
      @(posedge clk_sys_in);
      n++;
      if (rq.arvalid && arready) rq.arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) hang();
    v = rdata;
    rs = rresp;
    rq.rready <= 1'b0;
  endtask
  // issue a command and poll busy
  task automatic cmd(input logic [31:0] c);
    logic [31:0] v;
    logic [1:0]  rs;
    int          n;
    n = 0;
    wr(`BRF_OFS_CMD, c, rs);
    do begin
      rd(`BRF_OFS_CMD, v, rs);
      n++;
    end while (v[4] !== 1'b0 && n < 20);
    if (v[4] !== 1'b0) hang();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(`BRF_OFS_STATUS, d, r);
    chk(d, {16'h0, `BRF_PSW_RESET});
    foreach (rows[i]) begin
      cmd(rows[i].c);
      rd(`BRF_OFS_RDATA, d, r);
      if (rows[i].m !== 32'h0) chk(d & rows[i].m, rows[i].e);
    end
    // responses stand while the master stalls
    @(posedge clk_sys_in);
    wq <= '{1'b1, `BRF_OFS_EXT, 1'b1, 32'h0000_005A, 4'hF, 1'b0};
    rq <= '{1'b1, `BRF_OFS_CTRL, 1'b0};
    @(posedge clk_sys_in);
    wq.awvalid <= 1'b0;
    wq.wvalid  <= 1'b0;
    rq.arvalid <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk({30'h0, bvalid, rvalid}, 32'h3);
    wq.bready <= 1'b1;
    rq.rready <= 1'b1;
    @(posedge clk_sys_in);
    wq.bready <= 1'b0;
    rq.rready <= 1'b0;
    // every bank selected and written
    for (int b = 0; b < 8; b++) begin
      cmd({24'h0, b[3:0], 4'h6});
      cmd({8'h0, 8'hA0 + b[7:0], 16'h0002});
      rd(`BRF_OFS_STATUS, d, r);
      chk({29'h0, d[14:12]}, b);
    end
    // banks keep separate contents
    for (int b = 0; b < 8; b++) begin
      cmd({24'h0, b[3:0], 4'h6});
      cmd(32'h0000_0001);
      rd(`BRF_OFS_RDATA, d, r);
      chk(d & 32'hFF, 32'hA0 + b);
    end
    // context switch into bank five
    wr(`BRF_OFS_PC, 32'h000A_BCDE, r);
    wr(`BRF_OFS_STATUS, 32'h0000_0320, r);
    cmd(32'h0000_0057);
    rd(`BRF_OFS_STATUS, d, r);
    chk({29'h0, d[14:12]}, 32'h5);
    cmd(32'h0000_0023);
    rd(`BRF_OFS_RDATA, d, r);
    chk(d & 32'hFFFF, 32'hBCDE);
    cmd(32'h0000_0033);
    rd(`BRF_OFS_RDATA, d, r);
    chk(d & 32'hFFFF, {16'h0, 16'h0320 & `BRF_PSW_SAVE_MASK | 16'h0A00});
    // swap bit set: function name one reads byte five
    cmd(32'h0000_011D);
    rd(`BRF_OFS_RDATA, d, r);
    chk(d & 32'hFF, 32'hBC);
    // pops, push and status restore
    wr(`BRF_OFS_STACK, 32'h0000_1000, r); // set before any pop, clear of special areas
    wr(`BRF_OFS_STATUS, 32'h0000_0300, r);
    foreach (pops[i]) begin
      cmd(pops[i]);
      rd(`BRF_OFS_STACK, d, r);
      chk(d, {8'h0, sps[i]});
    end
    rd(`BRF_OFS_STATUS, d, r);
    chk({28'h0, d[11:8]}, 32'h3);
    // alias, placements and special window
    for (int i = 0; i < 4; i++) begin
      wr(`BRF_OFS_CTRL, {31'h0, xa[i][24]}, r);
      wr(`BRF_OFS_EXT, {8'h0, xa[i][23:0]}, r);
      cmd(32'h0000_0200);
      chk({31'h0, lockup}, {31'h0, i == 3});
      rd(`BRF_OFS_RDATA, d, r);
      chk(d & 32'hFF, {24'h0, xd[i]});
    end
    wr(`BRF_OFS_CMD, 32'h0000_0001, r);
    chk({30'h0, r}, 32'h2);
    rd(8'h1C, d, r);
    chk({r, d[29:0]}, 32'h8000_0000);
    // only reset clears the deadlock
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({31'h0, lockup}, 32'h0);
    rd(`BRF_OFS_STATUS, d, r);
    chk(d, 32'h0);
    end_sim();
  end
endmodule
